// file: design/fault_alert_indicator_regs.sv
// Purpose: fault logging, breaker fault and attention outputs, indicator drivers
// Assumes: all event and pin inputs are synchronous to core_clk
// Notes:   register port is the decoded side of the two-wire serial slave
//
// Summary of operation
// - trip log: slow bits 5:4, fast 1:0
// - slow and fast flags set by their comparators
// - breaker fault low is NOR of flags
// - trip flags latch until channel restart or disable
// - overcurrent shutdown pulls breaker fault low
// - no breaker fault for critical uv/ov
// - disabling a channel releases breaker fault
// - attention state mirrored in status bit 4
// - attention low while any flag set
// - off bit one turns indicator driver off while its blink bit is clear
// - blink bit toggles driver at 1 Hz
// - phase bits choose blink phase per indicator
// - pullup bits enable weak pullup when off
// - pin level register read only, bits 3:0
// - disabled indicator pin reads as input
// - uv, ov, overcurrent warnings set flags
`timescale 1ns/1ns
module fault_alert_indicator_regs #(
  parameter int NUM_CH     = 2,                                   // hot-swap channels
  parameter int NUM_IND    = 4,                                   // indicator pins
  parameter int BLINK_HALF = fault_alert_pkg::BLINK_HALF_CYCLES   // cycles per half blink
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               nrst,
  // register port
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  // channel events and state
  input  wire logic [NUM_CH-1:0]  slow_trip_evt,
  input  wire logic [NUM_CH-1:0]  fast_trip_evt,
  input  wire logic [NUM_CH-1:0]  ch_restart,
  input  wire logic [NUM_CH-1:0]  ch_enabled,
  input  wire logic [NUM_CH-1:0]  uv_warn_evt,
  input  wire logic [NUM_CH-1:0]  uv_crit_evt,
  input  wire logic [NUM_CH-1:0]  ov_warn_evt,
  input  wire logic [NUM_CH-1:0]  ov_crit_evt,
  input  wire logic [NUM_CH-1:0]  oc_warn_evt,
  // open-drain breaker fault and attention pins
  output logic      [NUM_CH-1:0]  breaker_fault_n,
  output logic      [NUM_CH-1:0]  breaker_fault_oe,
  output logic                    alert_n,
  output logic                    alert_oe,
  // open-drain indicator pins
  input  wire logic [NUM_IND-1:0] ind_in,
  output logic      [NUM_IND-1:0] ind_out,
  output logic      [NUM_IND-1:0] ind_oe,
  output logic      [NUM_IND-1:0] ind_pullup_en
);
  import fault_alert_pkg::*;

  localparam int CW = $clog2(BLINK_HALF + 1);  // blink divider width

  // fault flag state
  logic [NUM_CH-1:0]  slow_q, slow_d;          // slow trip flags
  logic [NUM_CH-1:0]  fast_q, fast_d;          // fast trip flags
  logic [NUM_CH-1:0]  uv_warn_q, uv_warn_d;    // undervoltage warning flags
  logic [NUM_CH-1:0]  uv_crit_q, uv_crit_d;    // undervoltage critical flags
  logic [NUM_CH-1:0]  ov_warn_q, ov_warn_d;    // overvoltage warning flags
  logic [NUM_CH-1:0]  ov_crit_q, ov_crit_d;    // overvoltage critical flags
  logic [NUM_CH-1:0]  ocw_q, ocw_d;            // overcurrent warning flags
  // control registers
  logic [7:0]         blink_set_q, blink_set_d;  // blink and off bits
  logic [7:0]         phase_pu_q, phase_pu_d;    // phase and pullup bits
  // pin level capture and read data
  logic [NUM_IND-1:0] pin_level_q;             // indicator pin levels
  logic [7:0]         rdata_q, rdata_d;        // registered read answer
  // blink divider
  logic [CW-1:0]      cnt_q, cnt_d;            // half period counter
  logic               blink_clk_q, blink_clk_d;  // internal 1 Hz square wave
  logic               blink_tick;              // one cycle enable each half period
  // decode helpers
  logic [NUM_CH-1:0]  trip_clr;                // restart or disable per channel
  logic               rd_uv, rd_ov, rd_ocw;    // clear-on-read strobes
  logic [NUM_IND-1:0] sink;                    // driver pulling its pin low
  logic [7:0]         third_status;            // assembled status word

  // read-clear strobes; a flag set in the same cycle survives the read
  assign rd_uv  = reg_rd && (reg_addr == ADDR_UV_FLAGS);
  assign rd_ov  = reg_rd && (reg_addr == ADDR_OV_FLAGS);
  assign rd_ocw = reg_rd && (reg_addr == ADDR_OCW_FLAGS);
  // a restart or a disabled channel drops its trip flags
  assign trip_clr = ch_restart | ~ch_enabled;

  // next state of all flags; set wins over every clear
  always_comb begin
    slow_d    = (slow_q & ~trip_clr) | slow_trip_evt;
    fast_d    = (fast_q & ~trip_clr) | fast_trip_evt;
    uv_warn_d = (uv_warn_q & {NUM_CH{~rd_uv}}) | uv_warn_evt;
    uv_crit_d = (uv_crit_q & {NUM_CH{~rd_uv}}) | uv_crit_evt;
    ov_warn_d = (ov_warn_q & {NUM_CH{~rd_ov}}) | ov_warn_evt;
    ov_crit_d = (ov_crit_q & {NUM_CH{~rd_ov}}) | ov_crit_evt;
    ocw_d     = (ocw_q & {NUM_CH{~rd_ocw}}) | oc_warn_evt;
  end

  // flag registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slow_q    <= '0;
      fast_q    <= '0;
      uv_warn_q <= '0;
      uv_crit_q <= '0;
      ov_warn_q <= '0;
      ov_crit_q <= '0;
      ocw_q     <= '0;
    end else begin
      slow_q    <= slow_d;
      fast_q    <= fast_d;
      uv_warn_q <= uv_warn_d;
      uv_crit_q <= uv_crit_d;
      ov_warn_q <= ov_warn_d;
      ov_crit_q <= ov_crit_d;
      ocw_q     <= ocw_d;
    end
  end

  // breaker fault follows only the trip flags, so critical uv/ov never drives it
  assign breaker_fault_oe = slow_q | fast_q;
  assign breaker_fault_n  = ~(slow_q | fast_q);
  // attention pin: nor over every flag register
  assign alert_n  = ~|{slow_q, fast_q, uv_warn_q, uv_crit_q,
                       ov_warn_q, ov_crit_q, ocw_q};
  assign alert_oe = ~alert_n;

  // control register writes
  always_comb begin
    blink_set_d = blink_set_q;
    phase_pu_d  = phase_pu_q;
    if (reg_wr && reg_addr == ADDR_BLINK_SET) begin
      blink_set_d = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_PHASE_PU) begin
      phase_pu_d = reg_wdata;
    end
  end

  // control registers and pin sampling
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blink_set_q <= RST_BLINK_SET;
      phase_pu_q  <= RST_PHASE_PU;
      pin_level_q <= '0;
    end else begin
      blink_set_q <= blink_set_d;
      phase_pu_q  <= phase_pu_d;
      pin_level_q <= ind_in;
    end
  end

  // 1 Hz divider: one enable pulse per half period toggles the square wave
  always_comb begin
    blink_tick  = (cnt_q == CW'(BLINK_HALF - 1));
    cnt_d       = blink_tick ? '0 : cnt_q + CW'(1);
    blink_clk_d = blink_clk_q ^ blink_tick;
  end

  // divider registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q       <= '0;
      blink_clk_q <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      blink_clk_q <= blink_clk_d;
    end
  end

  // per-indicator drivers; blink overrides the off bit
  for (genvar i = 0; i < NUM_IND; i++) begin : g_ind
    always_comb begin
      if (blink_set_q[BLINK_LSB + i]) begin
        // phase 0 sinks during the high half of the square wave
        sink[i] = phase_pu_q[PHASE_LSB + i] ? ~blink_clk_q : blink_clk_q;
      end else begin
        sink[i] = ~blink_set_q[OFF_LSB + i];
      end
    end
    // pullup only makes sense while the driver lets go of the pin
    assign ind_pullup_en[i] = phase_pu_q[PU_LSB + i] & ~sink[i];
  end
  assign ind_oe  = sink;
  assign ind_out = '0;  // open drain: only ever pulls low

  // status word: attention pin level in bit 4
  always_comb begin
    third_status            = 8'h00;
    third_status[ALERT_BIT] = alert_n;
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = 8'h00;
      unique case (reg_addr)
        ADDR_TRIP_LOG: begin
          rdata_d[SLOW_LSB +: NUM_CH] = slow_q;
          rdata_d[FAST_LSB +: NUM_CH] = fast_q;
        end
        ADDR_THIRD_STATUS_REG:   rdata_d = third_status;
        ADDR_UV_FLAGS: begin
          rdata_d[CRIT_LSB +: NUM_CH] = uv_crit_q;
          rdata_d[WARN_LSB +: NUM_CH] = uv_warn_q;
        end
        ADDR_OV_FLAGS: begin
          rdata_d[CRIT_LSB +: NUM_CH] = ov_crit_q;
          rdata_d[WARN_LSB +: NUM_CH] = ov_warn_q;
        end
        ADDR_OCW_FLAGS: rdata_d[WARN_LSB +: NUM_CH] = ocw_q;
        ADDR_BLINK_SET: rdata_d = blink_set_q;
        ADDR_PHASE_PU:  rdata_d = phase_pu_q;
        ADDR_PIN_LEVEL: rdata_d[NUM_IND-1:0] = pin_level_q;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  // read data holds until the next read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= RST_FLAGS;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // flag and breaker fault checks
  a_slow_trip_log: assert property (slow_trip_evt[0] |=> slow_q[0] && !breaker_fault_n[0])
    else $error("slow trip not logged");
  a_fast_flag_set: assert property (fast_trip_evt[1] |=> fast_q[1])
    else $error("fast trip flag not set");
  a_fault_nor_out: assert property (breaker_fault_n[0] == !(slow_q[0] || fast_q[0]))
    else $error("breaker fault not nor of flags");
  a_trip_hold_latch: assert property (slow_q[0] && ch_enabled[0] && !ch_restart[0]
    |=> slow_q[0])
    else $error("trip flag dropped without restart");
  a_fault_on_trip: assert property (fast_trip_evt[0] |=> breaker_fault_oe[0])
    else $error("no breaker fault after fast trip");
  a_crit_no_fault: assert property ((uv_crit_evt[0] || ov_crit_evt[0]) && !slow_q[0]
    && !fast_q[0] && !slow_trip_evt[0] && !fast_trip_evt[0] |=> breaker_fault_n[0])
    else $error("breaker fault from critical uv/ov");
  a_disable_release: assert property (!ch_enabled[0] && !slow_trip_evt[0]
    && !fast_trip_evt[0] |=> breaker_fault_n[0] && !breaker_fault_oe[0])
    else $error("breaker fault held while disabled");

  // a set in the cycle of a read must survive, so only quiet cycles are checked
  a_ocw_read_clear: assert property (rd_ocw && !oc_warn_evt[1] |=> !ocw_q[1])
    else $error("overcurrent warning not cleared by read");
  a_uv_warn_flag: assert property (uv_warn_evt[1] |=> uv_warn_q[1] && !alert_n)
    else $error("undervoltage warning not flagged");
  a_ov_crit_flag: assert property (ov_crit_evt[0] |=> ov_crit_q[0])
    else $error("overvoltage critical not flagged");

  // attention pin and status checks
  a_alert_mirror: assert property (reg_rd && reg_addr == ADDR_THIRD_STATUS_REG
    |=> reg_rdata[4] == $past(alert_n))
    else $error("status bit 4 differs from attention pin");
  a_alert_any_flag: assert property (oc_warn_evt[0] |=> !alert_n ##0 alert_oe)
    else $error("attention not asserted for a flag");

  // indicator checks; only a divider tick or a write may move a driver,
  // so a glitch on the pin from a stray decode shows up here
  a_off_bit_write: assert property (reg_wr && reg_addr == ADDR_BLINK_SET
    && reg_wdata[0] && !reg_wdata[4] |=> !ind_oe[0])
    else $error("indicator still driven after off bit");
  a_blink_phase: assert property (blink_set_q[4] && !phase_pu_q[4]
    |-> ind_oe[0] == blink_clk_q)
    else $error("blink phase wrong");
  a_blink_inverse: assert property (blink_set_q[5] && phase_pu_q[5]
    |-> ind_oe[1] == !blink_clk_q)
    else $error("inverted blink phase wrong");
  a_blink_hold: assert property (!blink_tick && !reg_wr |=> $stable(ind_oe))
    else $error("indicator moved without a divider tick");
  a_pullup_gate: assert property (ind_pullup_en[1] |-> phase_pu_q[1] && !ind_oe[1])
    else $error("pullup on while driver sinks");

  // pin level checks
  a_pin_sample: assert property (1'b1 |=> pin_level_q == $past(ind_in))
    else $error("pin level not sampled");
  a_pin_level_read: assert property (reg_rd && reg_addr == ADDR_PIN_LEVEL
    |=> reg_rdata == {4'h0, $past(pin_level_q[3:0])})
    else $error("pin level read wrong");

  // covers for the main scenarios
  c_slow_trip: cover property (slow_trip_evt[0] ##1 ch_restart[0] ##1 breaker_fault_n[0]);
  c_read_clear: cover property (oc_warn_evt[1] ##1 rd_ocw ##1 alert_n);
  c_blink_tick: cover property (blink_set_q[4] && blink_tick ##1 $changed(ind_oe[0]));
  c_chan_disable: cover property (slow_q[0] && !ch_enabled[0] ##1 breaker_fault_n[0]);

endmodule

// file: design/fault_alert_pkg.sv
// Purpose: shared constants for the fault, alert and indicator register bank
// Assumes: 8-bit register addresses and data behind an already decoded serial port
// Notes:   offsets are byte addresses of the device register map
package fault_alert_pkg;

  // register addresses
  localparam logic [7:0] ADDR_TRIP_LOG  = 8'h31;  // breaker trip log, read only
  localparam logic [7:0] ADDR_THIRD_STATUS_REG   = 8'h33;  // third status register
  localparam logic [7:0] ADDR_UV_FLAGS  = 8'h35;  // undervoltage flags, clear on read
  localparam logic [7:0] ADDR_OV_FLAGS  = 8'h36;  // overvoltage flags, clear on read
  localparam logic [7:0] ADDR_OCW_FLAGS = 8'h37;  // overcurrent warning flags, clear on read
  localparam logic [7:0] ADDR_BLINK_SET = 8'h43;  // indicator blink and off control
  localparam logic [7:0] ADDR_PHASE_PU  = 8'h44;  // indicator phase and pullup control
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h45;  // indicator pin level, read only

  // field positions
  localparam int FAST_LSB  = 0;  // fast trip flags in the trip log
  localparam int SLOW_LSB  = 4;  // slow trip flags in the trip log
  localparam int WARN_LSB  = 0;  // warning flags in uv and ov registers
  localparam int CRIT_LSB  = 4;  // critical flags in uv and ov registers
  localparam int OFF_LSB   = 0;  // indicator off bits
  localparam int BLINK_LSB = 4;  // indicator blink bits
  localparam int PU_LSB    = 0;  // indicator weak pullup bits
  localparam int PHASE_LSB = 4;  // indicator blink phase bits
  localparam int ALERT_BIT = 4;  // attention mirror in the third status register

  // reset values
  localparam logic [7:0] RST_BLINK_SET = 8'h0f;  // all indicators off, no blink
  localparam logic [7:0] RST_PHASE_PU  = 8'h00;
  localparam logic [7:0] RST_FLAGS     = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS     = 40;             // 25 MHz core clock
  localparam int BLINK_PERIOD_NS   = 1_000_000_000;  // 1 Hz blink period
  localparam int BLINK_HALF_CYCLES = BLINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

endpackage

// file: verification/host_model.sv
// Purpose: model of the system controller that owns the register port
// Assumes: strobes change at the falling edge of core_clk only
// Notes:   one access per call, strobe held across exactly one taking edge
`timescale 1ns/1ns
module host_model (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  // idle port, no strobe at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // write: address and data held until the strobe drops
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;  // stale data inverted so a late capture shows up
  endtask
  // read: the answer is taken by the bench monitor a cycle later
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
  endtask
endmodule

// file: verification/tb_top.sv
// Purpose: self-checking bench for the fault, alert and indicator bank
// Assumes: short blink half period of 8 cycles
// Notes:   read answers are queued by the driver and popped by a monitor
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
  import fault_alert_pkg::*;
  logic       core_clk, nrst, rd_q;                  // clock, reset, read seen
  logic       reg_wr, reg_rd;                        // driven by the host model
  logic [7:0] reg_addr, reg_wdata, reg_rdata;        // register port
  logic [1:0] slow, fast, rst_ch, en, bf_n, bf_oe;   // channel side
  logic [1:0] evt [5];                               // uv/ov warn/crit, oc warn
  logic [3:0] ind_in, ind_out, ind_oe, pu_en;        // indicator pins
  logic       alert_n, alert_oe;                     // attention pin
  logic [7:0] exp_q [$];                             // expected read answers
  int         mismatches, check_count, tog, ch, flip;  // counters, scratch
  logic [7:0] exp_v;                                 // oldest expected answer
  logic       prev_oe;                               // blink level one cycle ago
  localparam int BLINK_SIM = 8;                      // short half period for simulation
  host_model u_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  fault_alert_indicator_regs #(.BLINK_HALF(BLINK_SIM)) u_dut (.core_clk(core_clk), .nrst(nrst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .slow_trip_evt(slow), .fast_trip_evt(fast),
    .ch_restart(rst_ch), .ch_enabled(en), .uv_warn_evt(evt[0]), .uv_crit_evt(evt[1]),
    .ov_warn_evt(evt[2]), .ov_crit_evt(evt[3]), .oc_warn_evt(evt[4]),
    .breaker_fault_n(bf_n), .breaker_fault_oe(bf_oe), .alert_n(alert_n),
    .alert_oe(alert_oe), .ind_in(ind_in), .ind_out(ind_out), .ind_oe(ind_oe),
    .ind_pullup_en(pu_en));
  // clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // answer appears the cycle after the taking edge
  always @(posedge core_clk) rd_q <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("ERROR %0t: read answer with no expectation", $time);
      end else begin
        exp_v = exp_q.pop_front();
        `CHK(reg_rdata, exp_v)
      end
    end
  end
  // queue the expectation, then let the host read
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask
  // one-cycle event pulse on the channel or flag inputs
  task automatic pulse(input int k, input int c);
    @(negedge core_clk);
    if (k == 5) fast[c] = 1'b1;
    else if (k == 6) slow[c] = 1'b1;
    else if (k == 7) rst_ch[c] = 1'b1;
    else evt[k][c] = 1'b1;
    @(negedge core_clk);
    fast = 2'b00;
    slow = 2'b00;
    rst_ch = 2'b00;
    for (int i = 0; i < 5; i++) evt[i] = 2'b00;
  endtask
  // verdict in one place
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end
  // main sequence
  initial begin
    nrst   = 1'b0;
    slow   = 2'b00;
    fast   = 2'b00;
    rst_ch = 2'b00;
    en     = 2'b11;
    for (int i = 0; i < 5; i++) evt[i] = 2'b00;
    ind_in = 4'h0;
    void'($urandom(32'he74e));
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    rd_chk(8'h43, 8'h0f);
    rd_chk(8'h44, 8'h00);
    `CHK({alert_n, alert_oe, bf_n, ind_oe}, 8'hb0)
    $display("reset test done");
    pulse(5, 0);
    `CHK({bf_n, bf_oe, alert_n, alert_oe}, 6'b100101)
    rd_chk(8'h33, 8'h00);
    pulse(6, 1);
    rd_chk(8'h31, 8'h21);
    rd_chk(8'h31, 8'h21);
    `CHK(bf_n, 2'b00)
    pulse(7, 0);
    rd_chk(8'h31, 8'h20);
    @(negedge core_clk) en = 2'b01;
    @(negedge core_clk) `CHK({bf_n, bf_oe}, 4'b1100)
    rd_chk(8'h31, 8'h00);
    rd_chk(8'h33, 8'h10);
    en = 2'b11;
    // second round with the channels swapped, released by disable and restart
    pulse(6, 0);
    pulse(5, 1);
    rd_chk(8'h31, 8'h12);
    @(negedge core_clk) en = 2'b10;
    @(negedge core_clk) `CHK({bf_n, bf_oe}, 4'b0110)
    pulse(7, 1);
    en = 2'b11;
    rd_chk(8'h31, 8'h00);
    $display("breaker test done");
    for (int k = 0; k < 5; k++) begin
      flip = $urandom % 2;
      for (int c = 0; c < 2; c++) begin
        ch = c ^ flip;
        pulse(k, ch);
        `CHK({alert_n, alert_oe, bf_n}, 4'b0111)
        rd_chk(8'h35 + 8'(k / 2), 8'(1 << (ch + 4 * (k % 2))));
        rd_chk(8'h35 + 8'(k / 2), 8'h00);
        `CHK(alert_n, 1'b1)
      end
    end
    $display("flag test done");
    for (int n = 0; n < 3; n++) begin
      ind_in = (n == 0) ? 4'h3 : 4'($urandom);
      u_host.wr(8'h43, {4'h0, ind_in});
      u_host.wr(8'h44, 8'h0f);
      u_host.wr(8'h45, 8'hff);
      `CHK({ind_oe, pu_en}, {~ind_in, ind_in})
      rd_chk(8'h45, {4'h0, ind_in});
      `CHK(ind_out, 4'h0)
    end
    $display("indicator test done");
    u_host.wr(8'h44, 8'h20);
    u_host.wr(8'h43, 8'h3f);
    tog = 0;
    prev_oe = ind_oe[0];
    for (int n = 0; n < 40; n++) begin
      @(negedge core_clk);
      `CHK(ind_oe[3:1], {2'b00, ~ind_oe[0]})
      if (ind_oe[0] !== prev_oe) tog++;
      prev_oe = ind_oe[0];
    end
    `CHK(tog, 40 / BLINK_SIM)
    $display("blink test done");
    complete_run();
  end
endmodule
